// File: rtl/rvm_regs.svh
`ifndef RVM_REGS_SVH
`define RVM_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses on the serial bus)
`define RVM_OFS_R2_VCTRL 8'h21
`define RVM_OFS_R3_DECAY 8'h22
`define RVM_OFS_R3_VSEL 8'h23
`define RVM_OFS_R3_SLEEP 8'h24
`define RVM_OFS_R4_CTRL 8'h25
`define RVM_OFS_R5_CTRL 8'h26
`define RVM_OFS_R6_CTRL 8'h27
`define RVM_OFS_LR2_CTRL 8'h28
`define RVM_OFS_LR3_CTRL 8'h29

////////////////////////////////////////////////////////////////////////////////
// Register indices inside the bank
`define RVM_IX_R2_VCTRL 4'h0
`define RVM_IX_R3_DECAY 4'h1
`define RVM_IX_R3_VSEL 4'h2
`define RVM_IX_R3_SLEEP 4'h3
`define RVM_IX_R4_CTRL 4'h4
`define RVM_NUM_REGS 9
`define RVM_NUM_SW 5

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define RVM_CODE_MSB 7
`define RVM_CODE_LSB 1
`define RVM_DECAY_BIT 0
`define RVM_SLP1_BIT 0
`define RVM_SLP2_MSB 5
`define RVM_SLP2_LSB 4
`define RVM_MODE_BIT 1
`define RVM_ON_BIT 0
`define RVM_SLP2_ON 2'h3
`define RVM_NUM_MODE_RAILS 3

////////////////////////////////////////////////////////////////////////////////
// Writable-bit masks; cleared bits are read-only zero
`define RVM_WMASK_FULL 8'hFF
`define RVM_WMASK_VSEL 8'hFE
`define RVM_WMASK_CTRL 8'h3F

////////////////////////////////////////////////////////////////////////////////
// Serial bus target address, value arbitrary
`define RVM_I2C_ADDR 7'h2A

`endif

// File: rtl/rvm_pkg.sv
package rvm_pkg;

	typedef logic [7:0] rvm_byte_t;

	// Serial target states
	typedef enum logic [3:0] {
		RVM_ST_IDLE = 4'b0000,
		RVM_ST_DADDR = 4'b0001,
		RVM_ST_DACK = 4'b0010,
		RVM_ST_REGA = 4'b0011,
		RVM_ST_RACK = 4'b0100,
		RVM_ST_WDAT = 4'b0101,
		RVM_ST_WACK = 4'b0110,
		RVM_ST_RDAT = 4'b0111,
		RVM_ST_MACK = 4'b1000
	} rvm_state_t;

	// Register access request from the serial target
	typedef struct packed {
		logic wr;
		rvm_byte_t wr_addr;
		rvm_byte_t wdata;
		rvm_byte_t rd_addr;
	} rvm_req_t;

	// Factory one-time-programmed configuration
	typedef struct packed {
		logic [8:0][7:0] reg_init;
		logic [5:0] sleep_sel;
		logic [1:0] range_25mv;
	} rvm_otp_t;

	// Voltage-coded rail controls
	typedef struct packed {
		logic [6:0] code;
		logic range_25mv;
		logic decay;
		logic use_sleep;
	} rvm_vrail_t;

	// Switching and enable controls
	typedef struct packed {
		logic use_sleep;
		logic fpwm;
		logic on;
	} rvm_srail_t;

endpackage : rvm_pkg

// File: rtl/rvm_pin_sync.sv
`timescale 1ns/1ns
module rvm_pin_sync (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Pins
	input wire logic [3:0] pin_raw,
	output logic [3:0] pin_clean
);

	logic [3:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, out_q, out_d;

	////////////////////////////////////////////////////////////////////////////
	// Three stages; a change counts once stages two and three agree
	always_comb begin
		s1_d = pin_raw;
		s2_d = s1_q;
		s3_d = s2_q;
		out_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
		if (!rstn) begin
			s1_d = 4'hF;
			s2_d = 4'hF;
			s3_d = 4'hF;
			out_d = 4'hF;
		end
	end

	always_ff @(posedge core_clk) begin
		s1_q <= s1_d;
		s2_q <= s2_d;
		s3_q <= s3_d;
		out_q <= out_d;
	end

	assign pin_clean = out_q;

endmodule : rvm_pin_sync

// File: rtl/rvm_i2c_target.sv
`timescale 1ns/1ns
`include "rvm_regs.svh"
module rvm_i2c_target (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Filtered bus lines
	input wire logic scl,
	input wire logic sda,
	output logic sda_out,
	output logic sda_oen,
	// Register side
	output rvm_pkg::rvm_req_t req,
	input wire logic [7:0] rdata
);

	rvm_pkg::rvm_state_t st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d, byte_w;
	logic scl_q, scl_d, sda_q, sda_d, drive_q, drive_d, rw_q, rw_d, wr_q, wr_d;
	logic [7:0] wa_q, wa_d;
	logic start, stop, rise, fall;

	assign start = scl && sda_q && !sda;
	assign stop = scl && !sda_q && sda;
	assign rise = scl && !scl_q;
	assign fall = !scl && scl_q;
	assign byte_w = {sh_q[6:0], sda};

	////////////////////////////////////////////////////////////////////////////
	// Byte engine; ACK is given for every register address, mapped or not
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		drive_d = drive_q;
		rw_d = rw_q;
		wr_d = 1'b0;
		wa_d = wa_q;
		scl_d = scl;
		sda_d = sda;
		if (start) begin
			st_d = rvm_pkg::RVM_ST_DADDR;
			cnt_d = 3'h0;
			drive_d = 1'b0;
		end else if (stop) begin
			st_d = rvm_pkg::RVM_ST_IDLE;
			drive_d = 1'b0;
		end else begin
			case (st_q)
				rvm_pkg::RVM_ST_DADDR, rvm_pkg::RVM_ST_REGA, rvm_pkg::RVM_ST_WDAT: begin
					if (rise) begin
						sh_d = byte_w;
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == 3'h7) begin
							if (st_q == rvm_pkg::RVM_ST_DADDR) begin
								rw_d = sda;
								st_d = (byte_w[7:1] == `RVM_I2C_ADDR) ? rvm_pkg::RVM_ST_DACK
									: rvm_pkg::RVM_ST_IDLE;
							end else if (st_q == rvm_pkg::RVM_ST_REGA) begin
								ptr_d = byte_w;
								st_d = rvm_pkg::RVM_ST_RACK;
							end else begin
								wr_d = 1'b1;
								wa_d = ptr_q;
								ptr_d = ptr_q + 8'h01;
								st_d = rvm_pkg::RVM_ST_WACK;
							end
						end
					end
				end
				rvm_pkg::RVM_ST_DACK, rvm_pkg::RVM_ST_RACK, rvm_pkg::RVM_ST_WACK: begin
					if (fall && !drive_q) begin
						drive_d = 1'b1;
					end else if (fall) begin
						drive_d = 1'b0;
						cnt_d = 3'h0;
						if (st_q != rvm_pkg::RVM_ST_DACK) begin
							st_d = rvm_pkg::RVM_ST_WDAT;
						end else if (rw_q) begin
							sh_d = rdata;
							ptr_d = ptr_q + 8'h01;
							drive_d = !rdata[7];
							st_d = rvm_pkg::RVM_ST_RDAT;
						end else begin
							st_d = rvm_pkg::RVM_ST_REGA;
						end
					end
				end
				rvm_pkg::RVM_ST_RDAT: begin
					if (fall) begin
						drive_d = !sh_q[7];
					end else if (rise) begin
						sh_d = {sh_q[6:0], 1'b1};
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == 3'h7) begin
							st_d = rvm_pkg::RVM_ST_MACK;
						end
					end
				end
				rvm_pkg::RVM_ST_MACK: begin
					if (fall) begin
						drive_d = 1'b0;
					end else if (rise) begin
						if (!sda) begin
							sh_d = rdata;
							ptr_d = ptr_q + 8'h01;
							st_d = rvm_pkg::RVM_ST_RDAT;
						end else begin
							st_d = rvm_pkg::RVM_ST_IDLE;
						end
					end
				end
				default: begin
					drive_d = 1'b0;
				end
			endcase
		end
		if (!rstn) begin
			st_d = rvm_pkg::RVM_ST_IDLE;
			cnt_d = 3'h0;
			sh_d = 8'h00;
			ptr_d = 8'h00;
			drive_d = 1'b0;
			rw_d = 1'b0;
			wr_d = 1'b0;
			wa_d = 8'h00;
			// Rest at the idle bus level so release gives no false edge
			scl_d = 1'b1;
			sda_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		st_q <= st_d;
		cnt_q <= cnt_d;
		sh_q <= sh_d;
		ptr_q <= ptr_d;
		drive_q <= drive_d;
		rw_q <= rw_d;
		wr_q <= wr_d;
		wa_q <= wa_d;
		scl_q <= scl_d;
		sda_q <= sda_d;
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oen = !drive_q;
	assign req = '{wr: wr_q, wr_addr: wa_q, wdata: sh_q, rd_addr: ptr_q};

endmodule : rvm_i2c_target

// File: rtl/rvm_rail_regs.sv
`timescale 1ns/1ns
`include "rvm_regs.svh"
module rvm_rail_regs (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Serial bus, open drain data
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oen,
	// Sleep pins, active low
	input wire logic sleep_pin_a,
	input wire logic sleep_pin_b,
	// Factory configuration
	input rvm_pkg::rvm_otp_t otp,
	// Rail enables from control input pin sequencing
	input wire logic [4:0] pin_rail_en,
	// Rail controls
	output rvm_pkg::rvm_vrail_t rail2_ctl,
	output rvm_pkg::rvm_vrail_t rail3_ctl,
	output rvm_pkg::rvm_srail_t [4:0] sw_ctl
);

	logic [3:0] pins_clean;
	rvm_pkg::rvm_req_t req;
	rvm_pkg::rvm_byte_t regs_q [0:8];
	rvm_pkg::rvm_byte_t regs_d [0:8];
	rvm_pkg::rvm_byte_t rdata;
	rvm_pkg::rvm_vrail_t r2_q, r2_d, r3_q, r3_d;
	rvm_pkg::rvm_srail_t [4:0] sw_q, sw_d;

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a >= `RVM_OFS_R2_VCTRL) && (a <= `RVM_OFS_LR3_CTRL);
	endfunction : is_mapped

	function automatic logic [3:0] reg_ix(input logic [7:0] a);
		logic [7:0] d;
		d = a - `RVM_OFS_R2_VCTRL;
		reg_ix = d[3:0];
	endfunction : reg_ix

	// Writable bits; the gaps are the read-only reserved bits
	function automatic logic [7:0] wmask(input logic [3:0] ix);
		if (ix == `RVM_IX_R3_VSEL) begin
			wmask = `RVM_WMASK_VSEL;
		end else if (ix >= `RVM_IX_R4_CTRL) begin
			wmask = `RVM_WMASK_CTRL;
		end else begin
			wmask = `RVM_WMASK_FULL;
		end
	endfunction : wmask

	// Sleep request: selected pin is low
	function automatic logic pin_low(input logic sel, input logic [1:0] p);
		pin_low = sel ? !p[1] : !p[0];
	endfunction : pin_low

	////////////////////////////////////////////////////////////////////////////
	// Pin conditioning: scl, sda and both sleep pins
	rvm_pin_sync u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.pin_raw({sleep_pin_b, sleep_pin_a, sda_in, scl_pin}),
		.pin_clean(pins_clean)
	);

	////////////////////////////////////////////////////////////////////////////
	// Serial target
	rvm_i2c_target u_i2c (
		.core_clk(core_clk),
		.rstn(rstn),
		.scl(pins_clean[0]),
		.sda(pins_clean[1]),
		.sda_out(sda_out),
		.sda_oen(sda_oen),
		.req(req),
		.rdata(rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register bank; reserved writable bits just store what the host wrote
	always_comb begin
		for (int i = 0; i < `RVM_NUM_REGS; i++) begin
			regs_d[i] = regs_q[i];
		end
		if (!rstn) begin
			for (int i = 0; i < `RVM_NUM_REGS; i++) begin
				regs_d[i] = otp.reg_init[i] & wmask(4'(i));
			end
		end else if (req.wr && is_mapped(req.wr_addr)) begin
			regs_d[reg_ix(req.wr_addr)] = req.wdata & wmask(reg_ix(req.wr_addr));
		end
	end

	always_ff @(posedge core_clk) begin
		for (int i = 0; i < `RVM_NUM_REGS; i++) begin
			regs_q[i] <= regs_d[i];
		end
	end

	// Read data; unmapped addresses read as zero
	always_comb begin
		rdata = 8'h00;
		if (is_mapped(req.rd_addr)) begin
			rdata = regs_q[reg_ix(req.rd_addr)] & wmask(reg_ix(req.rd_addr));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Voltage-coded rails; rail two sleep lives outside this bank
	always_comb begin
		r2_d.code = regs_q[`RVM_IX_R2_VCTRL][`RVM_CODE_MSB:`RVM_CODE_LSB];
		r2_d.range_25mv = otp.range_25mv[0];
		r2_d.decay = regs_q[`RVM_IX_R2_VCTRL][`RVM_DECAY_BIT];
		r2_d.use_sleep = 1'b0;
		// Spare bits of the decay register are never read here
		r3_d.decay = regs_q[`RVM_IX_R3_DECAY][`RVM_DECAY_BIT];
		r3_d.range_25mv = otp.range_25mv[1];
		r3_d.use_sleep = regs_q[`RVM_IX_R3_SLEEP][`RVM_SLP1_BIT]
			&& pin_low(otp.sleep_sel[0], pins_clean[3:2]);
		if (r3_d.use_sleep) begin
			r3_d.code = regs_q[`RVM_IX_R3_SLEEP][`RVM_CODE_MSB:`RVM_CODE_LSB];
		end else begin
			r3_d.code = regs_q[`RVM_IX_R3_VSEL][`RVM_CODE_MSB:`RVM_CODE_LSB];
		end
		if (!rstn) begin
			r2_d = '0;
			r3_d = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		r2_q <= r2_d;
		r3_q <= r3_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// Switching rails and linear regulators
	// Reserved codes 01 and 10 fall back to the normal code, so a stray
	// host write cannot put a rail into an undefined sleep state.
	always_comb begin
		for (int i = 0; i < `RVM_NUM_SW; i++) begin
			sw_d[i].use_sleep = (regs_q[i + 4][`RVM_SLP2_MSB:`RVM_SLP2_LSB] == `RVM_SLP2_ON)
				&& pin_low(otp.sleep_sel[i + 1], pins_clean[3:2]);
			sw_d[i].fpwm = (i < `RVM_NUM_MODE_RAILS) && regs_q[i + 4][`RVM_MODE_BIT];
			sw_d[i].on = regs_q[i + 4][`RVM_ON_BIT] && pin_rail_en[i];
		end
		if (!rstn) begin
			sw_d = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		sw_q <= sw_d;
	end

	assign rail2_ctl = r2_q;
	assign rail3_ctl = r3_q;
	assign sw_ctl = sw_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_normal_code: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> rail2_ctl.code == $past(regs_q[0][7:1])
	) else $error("rail two code does not follow its register");

	a_range_fixed: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> rail3_ctl.range_25mv == $past(otp.range_25mv[1])
	) else $error("rail three step range not from factory setting");

	a_decay_follow: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> rail3_ctl.decay == $past(regs_q[1][0])
	) else $error("rail three decay select mismatch");

	a_spare_store: assert property (
		@(posedge core_clk) disable iff (!rstn)
		req.wr && req.wr_addr == 8'h22 |=> regs_q[1][7:1] == $past(req.wdata[7:1])
	) else $error("spare field did not store the write");

	a_sleep_gate: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!regs_q[3][0] |=> !rail3_ctl.use_sleep
	) else $error("rail three sleeps while disabled");

	a_sleep_code: assert property (
		@(posedge core_clk) disable iff (!rstn)
		rail3_ctl.use_sleep |-> rail3_ctl.code == $past(regs_q[3][7:1])
	) else $error("rail three sleep code not applied");

	a_pin_select: assert property (
		@(posedge core_clk) disable iff (!rstn)
		sw_ctl[0].use_sleep
			|-> (otp.sleep_sel[1] ? !$past(pins_clean[3]) : !$past(pins_clean[2]))
	) else $error("rail four sleeps without its pin low");

	a_two_bit_en: assert property (
		@(posedge core_clk) disable iff (!rstn)
		regs_q[5][5:4] != 2'h3 |=> !sw_ctl[1].use_sleep
	) else $error("rail five sleeps without enable 11");

	a_mode_out: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> sw_ctl[2].fpwm == $past(regs_q[6][1])
	) else $error("rail six mode mismatch");

	a_off_override: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!regs_q[7][0] |=> !sw_ctl[3].on
	) else $error("regulator two on while on bit is clear");

	a_ro_bits: assert property (
		@(posedge core_clk) disable iff (!rstn)
		req.wr && req.wr_addr == 8'h29 ##1 1'b1 |-> regs_q[8][7:6] == 2'h0 && rdata[7:6] == 2'h0
	) else $error("read-only bits took a write");

	a_otp_load: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$rose(rstn) |-> regs_q[0] == $past(otp.reg_init[0]) && regs_q[4] == ($past(otp.reg_init[4]) & 8'h3F)
	) else $error("reset values not loaded from factory setting");

	////////////////////////////////////////////////////////////////////////////
	// Further checks: the other rails, and the paths a quick test rarely reaches
	a_normal_fallback: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) && !rail3_ctl.use_sleep |-> rail3_ctl.code == $past(regs_q[2][7:1])
	) else $error("rail three awake but not on its normal code");

	a_range_rail2: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> rail2_ctl.range_25mv == $past(otp.range_25mv[0])
	) else $error("rail two step range not from factory setting");

	a_decay_rail2: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> rail2_ctl.decay == $past(regs_q[0][0])
	) else $error("rail two decay select mismatch");

	a_spare_read: assert property (
		@(posedge core_clk) disable iff (!rstn)
		req.rd_addr == `RVM_OFS_R3_DECAY |-> rdata == regs_q[1]
	) else $error("spare field does not read back whole");

	a_sleep_enter: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) && $past(regs_q[3][0]) && !otp.sleep_sel[0] && !$past(pins_clean[2])
			|-> rail3_ctl.use_sleep
	) else $error("rail three ignores its sleep request");

	a_rail3_pin: assert property (
		@(posedge core_clk) disable iff (!rstn)
		rail3_ctl.use_sleep
			|-> (otp.sleep_sel[0] ? !$past(pins_clean[3]) : !$past(pins_clean[2]))
	) else $error("rail three sleeps without its pin low");

	a_rail6_pin: assert property (
		@(posedge core_clk) disable iff (!rstn)
		sw_ctl[2].use_sleep
			|-> (otp.sleep_sel[3] ? !$past(pins_clean[3]) : !$past(pins_clean[2]))
	) else $error("rail six sleeps without its pin low");

	a_sleep_on: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) && $past(regs_q[8][5:4]) == `RVM_SLP2_ON && otp.sleep_sel[5]
			&& !$past(pins_clean[3]) |-> sw_ctl[4].use_sleep
	) else $error("regulator three ignores its sleep request");

	a_two_bit_rail4: assert property (
		@(posedge core_clk) disable iff (!rstn)
		regs_q[4][5:4] != 2'h3 |=> !sw_ctl[0].use_sleep
	) else $error("rail four sleeps without enable 11");

	a_mode_rail4: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> sw_ctl[0].fpwm == $past(regs_q[4][1])
	) else $error("rail four mode mismatch");

	a_mode_rail5: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> sw_ctl[1].fpwm == $past(regs_q[5][1])
	) else $error("rail five mode mismatch");

	a_on_follow: assert property (
		@(posedge core_clk) disable iff (!rstn)
		$past(rstn) |-> sw_ctl[4].on == ($past(regs_q[8][0]) && $past(pin_rail_en[4]))
	) else $error("regulator three enable mismatch");

	a_off_rail4: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!regs_q[4][0] |=> !sw_ctl[0].on
	) else $error("rail four on while on bit is clear");

	a_ro_vsel: assert property (
		@(posedge core_clk) disable iff (!rstn)
		req.rd_addr == `RVM_OFS_R3_VSEL |-> !rdata[0] && !regs_q[2][0]
	) else $error("read-only bit of rail three voltage register set");

endmodule : rvm_rail_regs

// File: sim/rvm_i2c_host.sv
`timescale 1ns/1ns
`include "rvm_regs.svh"
module rvm_i2c_host (
	// Clock
	input wire logic core_clk,
	// Open-drain bus, 1 means released
	output logic scl,
	output logic sda_rel,
	input wire logic sda_wire
);
	// Idle bus: both lines left to the pull-ups
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick

	// SDA moves two cycles after SCL falls so the filtered edges stay in order
	task automatic bitx(input logic b, output logic s);
		tick(2);
		sda_rel = b;
		tick(8);
		scl = 1'b1;
		tick(5);
		s = sda_wire;
		tick(5);
		scl = 1'b0;
	endtask : bitx

	// Eight bits out, then the ninth clock carries the acknowledge
	task automatic bytex(input logic [7:0] t, input logic m, output logic [7:0] d, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(t[i], s);
			d[i] = s;
		end
		bitx(m, s);
		a = !s;
	endtask : bytex

	// Start or repeated start: SDA falls while SCL is high
	task automatic start();
		tick(2);
		sda_rel = 1'b1;
		tick(8);
		scl = 1'b1;
		tick(8);
		sda_rel = 1'b0;
		tick(8);
		scl = 1'b0;
	endtask : start

	task automatic stop();
		tick(2);
		sda_rel = 1'b0;
		tick(8);
		scl = 1'b1;
		tick(8);
		sda_rel = 1'b1;
		tick(8);
	endtask : stop

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, wd, output logic ok);
		logic [7:0] d;
		logic a0, a1, a2;
		start();
		bytex({dev, 1'b0}, 1'b1, d, a0);
		bytex(ra, 1'b1, d, a1);
		bytex(wd, 1'b1, d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask : write_reg

	// Single byte read, ended by a NACK from the host
	task automatic read_reg(input logic [7:0] ra, output logic [7:0] rd, output logic ok);
		logic [7:0] d;
		logic a0, a1, a2, a3;
		start();
		bytex({`RVM_I2C_ADDR, 1'b0}, 1'b1, d, a0);
		bytex(ra, 1'b1, d, a1);
		start();
		bytex({`RVM_I2C_ADDR, 1'b1}, 1'b1, d, a2);
		bytex(8'hFF, 1'b1, rd, a3);
		stop();
		ok = a0 & a1 & a2;
	endtask : read_reg
endmodule : rvm_i2c_host

// File: sim/tb_rvm_rail_regs.sv
`timescale 1ns/1ns
`include "rvm_regs.svh"
module tb_rvm_rail_regs;
	logic core_clk, rstn, scl, sda_rel, sda_wire, sda_out, sda_oen, ok;
	logic sleep_pin_a, sleep_pin_b;
	logic [4:0] pin_rail_en;
	logic [7:0] d;
	logic [7:0] sh [9];
	logic [7:0] ini [9] = '{8'h64, 8'h40, 8'h41, 8'h21, 8'hCF, 8'h0D, 8'h3D, 8'h0D, 8'hCC};
	rvm_pkg::rvm_otp_t otp;
	rvm_pkg::rvm_vrail_t rail2_ctl, rail3_ctl;
	rvm_pkg::rvm_srail_t [4:0] sw_ctl;
	int fail_count = 0;
	int check_count = 0;

	// Open-drain wire: either party can pull it low
	assign sda_wire = sda_rel & (sda_oen | sda_out);

	rvm_rail_regs DUT (.core_clk(core_clk), .rstn(rstn), .scl_pin(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oen(sda_oen), .sleep_pin_a(sleep_pin_a),
		.sleep_pin_b(sleep_pin_b), .otp(otp), .pin_rail_en(pin_rail_en),
		.rail2_ctl(rail2_ctl), .rail3_ctl(rail3_ctl), .sw_ctl(sw_ctl));
	rvm_i2c_host host (.core_clk(core_clk), .scl(scl), .sda_rel(sda_rel), .sda_wire(sda_wire));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick

	function automatic logic [7:0] wmask(input int i);
		return i == 2 ? `RVM_WMASK_VSEL : i > 3 ? `RVM_WMASK_CTRL : `RVM_WMASK_FULL;
	endfunction : wmask

	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		check_count++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask : chk

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	// Shadow keeps what a write should leave behind after read-only bits drop
	task automatic wr(input int i, input logic [7:0] v);
		host.write_reg(`RVM_I2C_ADDR, 8'h21 + 8'(i), v, ok);
		chk("write ack", 10'h1, {9'h0, ok});
		sh[i] = v & wmask(i);
	endtask : wr

	task automatic rd(input int i);
		host.read_reg(8'h21 + 8'(i), d, ok);
		chk("read ack", 10'h1, {9'h0, ok});
		chk($sformatf("reg %0d", i), {2'h0, sh[i]}, {2'h0, d});
	endtask : rd

	task automatic do_reset();
		rstn = 1'b0;
		tick(4);
		rstn = 1'b1;
		for (int i = 0; i < 9; i++) begin
			sh[i] = ini[i] & wmask(i);
		end
		tick(6);
	endtask : do_reset

	// Pin changes need three sync stages plus the output register
	task automatic check_outs();
		logic [5:0] s;
		tick(6);
		for (int k = 0; k < 6; k++) begin
			s[k] = otp.sleep_sel[k] ? !sleep_pin_b : !sleep_pin_a;
			s[k] &= k == 0 ? sh[3][0] : sh[3 + k][5:4] == 2'h3;
		end
		chk("rail2", {sh[0][7:1], otp.range_25mv[0], sh[0][0], 1'b0}, rail2_ctl);
		chk("rail3", {s[0] ? sh[3][7:1] : sh[2][7:1], otp.range_25mv[1], sh[1][0], s[0]},
			rail3_ctl);
		for (int i = 0; i < 5; i++) begin
			chk("switch", {7'h0, s[i + 1], i < 3 && sh[4 + i][1], sh[4 + i][0] & pin_rail_en[i]},
				10'(sw_ctl[i]));
		end
	endtask : check_outs

	// Main sequence
	initial begin
		rstn = 1'b0;
		sleep_pin_a = 1'b1;
		sleep_pin_b = 1'b1;
		pin_rail_en = 5'h1F;
		otp.sleep_sel = 6'h2A;
		otp.range_25mv = 2'h2;
		for (int i = 0; i < 9; i++) begin
			otp.reg_init[i] = ini[i];
		end
		do_reset();
		for (int i = 0; i < 9; i++) begin
			rd(i);
		end
		check_outs();
		$display("Test reset values done");
		wr(0, 8'hC9);
		wr(1, 8'hA5);
		wr(2, 8'hFF);
		rd(1);
		rd(2);
		check_outs();
		$display("Test codes done");
		// Top bits set on purpose: they are read-only and must stay zero
		for (int i = 0; i < 5; i++) begin
			for (int v = 0; v < 4; v++) begin
				wr(i + 4, i < 3 ? {4'hC, 2'h3, v[1:0]} : {4'hC, 3'h6, v[0]});
				check_outs();
			end
			rd(i + 4);
		end
		pin_rail_en = 5'h0A;
		check_outs();
		$display("Test mode and enable done");
		pin_rail_en = 5'h1F;
		wr(3, 8'h5B);
		for (int i = 4; i < 9; i++) begin
			wr(i, 8'h3D);
		end
		for (int p = 0; p < 4; p++) begin
			sleep_pin_a = p[0];
			sleep_pin_b = p[1];
			check_outs();
		end
		wr(3, 8'h5A);
		for (int i = 4; i < 9; i++) begin
			wr(i, 8'h0D);
		end
		sleep_pin_a = 1'b0;
		sleep_pin_b = 1'b0;
		check_outs();
		$display("Test sleep done");
		host.write_reg(`RVM_I2C_ADDR ^ 7'h01, 8'h21, 8'h00, ok);
		chk("foreign ack", 10'h0, {9'h0, ok});
		rd(0);
		host.read_reg(8'h30, d, ok);
		chk("unmapped", 10'h0, {2'h0, d});
		do_reset();
		rd(4);
		check_outs();
		$display("Test refusals and reset done");
		give_verdict();
	end

	// Cut a hung run short
	initial begin
		repeat (95000) @(posedge core_clk);
		fail_count++;
		give_verdict();
	end
endmodule : tb_rvm_rail_regs
